// file: common/accessory_detect_consts.vh
// Constants for the accessory detection readout logic.
// Assumes a single 25 MHz system clock; times are in microseconds.
`ifndef ACCESSORY_DETECT_CONSTS_VH
`define ACCESSORY_DETECT_CONSTS_VH

`define CLK_MHZ 25
// Rising debounce of the valid comparator, least time 15 ms
`define VALID_RISE_US 15000
// Falling debounce of the valid comparator, least time 0.5 ms (500 us)
`define VALID_FALL_US 500
// Flag update budget for the session level
`define FLAG_BUDGET_US 100
// Session comparator settling, fits inside the budget
`define SESSION_FILT_US 2
// SE1 debounce, about 1 ms
`define SE1_DEB_US 1000

`define VALID_RISE_CYC (`VALID_RISE_US * `CLK_MHZ)
`define VALID_FALL_CYC (`VALID_FALL_US * `CLK_MHZ)
`define SESSION_FILT_CYC (`SESSION_FILT_US * `CLK_MHZ)
`define SE1_DEB_CYC (`SE1_DEB_US * `CLK_MHZ)

// ID status codes {open, grounded}
`define ID_CODE_MID 2'h0
`define ID_CODE_GND 2'h1
`define ID_CODE_OPEN 2'h2
`define ID_CODE_FACTORY 2'h3

// Reset value of the ID pull-up select
`define ID_PULLUP_RESET 1'h0

`endif

// file: hdl/accessory_detect_logic.v
// Readout logic for accessory detection: VBUS levels, ID line, SE1.
// Assumes analog comparator outputs arrive asynchronously and that
// software drives the clear and control inputs from the ref_clk domain.
//
// Notes on behaviour
// - Three VBUS comparator inputs: valid, session, low
// - Any VBUS flag change raises level interrupt
// - Three VBUS flags follow their comparators
// - Valid comparator: slow rise, fast fall debounce
// - Session flag rises within 100us, valid flag only after its 15ms rise debounce
// - ID line classified into four conditions
// - ID status coded as two flags
// - Pull-up select chooses source, resets zero
// - ID code change raises ID interrupt
// - ID and charger interrupts work regulator off
// - Any detection interrupt drives output pin high
// - Factory mode suppressed while current pull-up
// - SE1 asserted when both data lines high
// - SE1 debounced 1ms, interrupt both edges
// - SE1 level flag follows debounced detector
// - SE1 sense zero below charger threshold
`timescale 1ns/1ps
`include "accessory_detect_consts.vh"

module accessory_detect_logic #(
    parameter VALID_RISE_CYC = `VALID_RISE_CYC,
    parameter VALID_FALL_CYC = `VALID_FALL_CYC,
    parameter SESSION_FILT_CYC = `SESSION_FILT_CYC,
    parameter SE1_DEB_CYC = `SE1_DEB_CYC
) (
    input wire ref_clk,
    input wire resetn,
    input wire vbus_cmp_valid,
    input wire vbus_cmp_session,
    input wire vbus_cmp_low,
    input wire id_cmp_ground,
    input wire id_cmp_open,
    input wire id_cmp_factory,
    input wire data_plus_high,
    input wire data_minus_high,
    input wire charger_detect_threshold,
    input wire charger_detect_event,
    input wire pullup_select_wr,
    input wire pullup_select_wdata,
    input wire clear_vbus_irq,
    input wire clear_id_irq,
    input wire clear_se1_irq,
    input wire clear_charger_irq,
    output reg vbus_valid_flag,
    output reg vbus_session_flag,
    output reg vbus_low_flag,
    output reg id_open_flag,
    output reg id_grounded_flag,
    output reg id_pullup_select,
    output reg se1_level_flag,
    output reg se1_sense_flag,
    output reg se1_raw_to_charger,
    output reg vbus_level_irq,
    output reg id_change_irq,
    output reg se1_change_irq,
    output reg charger_detect_irq,
    output reg irq_out_pin
);

    localparam NSYNC = 10;

    // Two-stage synchronisers for every asynchronous input
    wire [NSYNC-1:0] async_in;
    reg [NSYNC-1:0] sync1_q;
    reg [NSYNC-1:0] sync2_q;
    assign async_in = {charger_detect_event, charger_detect_threshold, data_minus_high,
                       data_plus_high, id_cmp_factory, id_cmp_open, id_cmp_ground,
                       vbus_cmp_low, vbus_cmp_session, vbus_cmp_valid};

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= {NSYNC{1'b0}};
            sync2_q <= {NSYNC{1'b0}};
        end else begin
            sync1_q <= async_in;
            sync2_q <= sync1_q;
        end
    end

    wire s_valid = sync2_q[0];
    wire s_session = sync2_q[1];
    wire s_low = sync2_q[2];
    wire s_id_grounded_flag = sync2_q[3];
    wire s_id_open = sync2_q[4];
    wire s_id_fact = sync2_q[5];
    wire s_dp = sync2_q[6];
    wire s_dm = sync2_q[7];
    wire s_chg_thr = sync2_q[8];
    wire s_chg_evt = sync2_q[9];

    // Valid comparator: asymmetric debounce, long rise, short fall
    reg valid_db_q;
    reg [23:0] valid_cnt_q;
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            valid_db_q <= 1'b0;
            valid_cnt_q <= 24'h000000;
        end else if (s_valid == valid_db_q) begin
            valid_cnt_q <= 24'h000000;
        end else if (valid_db_q == 1'b0 && valid_cnt_q >= VALID_RISE_CYC - 1) begin
            valid_db_q <= 1'b1;
            valid_cnt_q <= 24'h000000;
        end else if (valid_db_q == 1'b1 && valid_cnt_q >= VALID_FALL_CYC - 1) begin
            valid_db_q <= 1'b0;
            valid_cnt_q <= 24'h000000;
        end else begin
            valid_cnt_q <= valid_cnt_q + 24'h000001;
        end
    end

    // Session comparator: short glitch filter, well inside the flag budget
    reg session_db_q;
    reg [11:0] session_cnt_q;
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            session_db_q <= 1'b0;
            session_cnt_q <= 12'h000;
        end else if (s_session == session_db_q) begin
            session_cnt_q <= 12'h000;
        end else if (session_cnt_q >= SESSION_FILT_CYC - 1) begin
            session_db_q <= s_session;
            session_cnt_q <= 12'h000;
        end else begin
            session_cnt_q <= session_cnt_q + 12'h001;
        end
    end

    // SE1 detect and symmetric debounce
    wire se1_raw = s_dp & s_dm;
    reg se1_db_q;
    reg [15:0] se1_cnt_q;
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            se1_db_q <= 1'b0;
            se1_cnt_q <= 16'h0000;
        end else if (se1_raw == se1_db_q) begin
            se1_cnt_q <= 16'h0000;
        end else if (se1_cnt_q >= SE1_DEB_CYC - 1) begin
            se1_db_q <= se1_raw;
            se1_cnt_q <= 16'h0000;
        end else begin
            se1_cnt_q <= se1_cnt_q + 16'h0001;
        end
    end

    // Pull-up select; written by software, resets to the resistor pull-up
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            id_pullup_select <= `ID_PULLUP_RESET;
        else if (pullup_select_wr)
            id_pullup_select <= pullup_select_wdata;
    end

    // ID classification; factory level ignored with the current source
    // selected, since an open line then looks like factory mode
    reg [1:0] id_code_d;
    always @* begin
        if (s_id_fact && !id_pullup_select)
            id_code_d = `ID_CODE_FACTORY;
        else if (s_id_open || s_id_fact)
            id_code_d = `ID_CODE_OPEN;
        else if (s_id_grounded_flag)
            id_code_d = `ID_CODE_GND;
        else
            id_code_d = `ID_CODE_MID;
    end

    // Flag registers, plus one-cycle history for change detection
    reg [1:0] id_code_q;
    reg se1_db_prev_q;
    reg chg_evt_prev_q;
    reg [2:0] vbus_prev_q;
    wire [2:0] vbus_now = {s_low, session_db_q, valid_db_q};
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            vbus_valid_flag <= 1'b0;
            vbus_session_flag <= 1'b0;
            vbus_low_flag <= 1'b0;
            id_open_flag <= 1'b0;
            id_grounded_flag <= 1'b0;
            id_code_q <= `ID_CODE_MID;
            se1_level_flag <= 1'b0;
            se1_sense_flag <= 1'b0;
            se1_raw_to_charger <= 1'b0;
            se1_db_prev_q <= 1'b0;
            chg_evt_prev_q <= 1'b0;
            vbus_prev_q <= 3'h0;
        end else begin
            vbus_valid_flag <= valid_db_q;
            vbus_session_flag <= session_db_q;
            vbus_low_flag <= s_low;
            id_code_q <= id_code_d;
            id_open_flag <= id_code_d[1];
            id_grounded_flag <= id_code_d[0];
            se1_level_flag <= se1_db_q;
            se1_sense_flag <= se1_db_q & s_chg_thr;
            se1_raw_to_charger <= se1_raw;
            se1_db_prev_q <= se1_db_q;
            chg_evt_prev_q <= s_chg_evt;
            vbus_prev_q <= vbus_now;
        end
    end

    // Change events; all logic runs from ref_clk so no dependence on
    // the USB supply regulator state
    wire vbus_evt = |(vbus_now ^ vbus_prev_q);
    wire id_evt = (id_code_d != id_code_q);
    wire se1_evt = se1_db_q ^ se1_db_prev_q;
    wire chg_evt = s_chg_evt & ~chg_evt_prev_q;

    // Sticky interrupts; a new event wins over a clear in the same cycle
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            vbus_level_irq <= 1'b0;
            id_change_irq <= 1'b0;
            se1_change_irq <= 1'b0;
            charger_detect_irq <= 1'b0;
        end else begin
            vbus_level_irq <= vbus_evt | (vbus_level_irq & ~clear_vbus_irq);
            id_change_irq <= id_evt | (id_change_irq & ~clear_id_irq);
            se1_change_irq <= se1_evt | (se1_change_irq & ~clear_se1_irq);
            charger_detect_irq <= chg_evt | (charger_detect_irq & ~clear_charger_irq);
        end
    end

    // Pin follows the OR of the next latched state, straight from a flop
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            irq_out_pin <= 1'b0;
        else
            irq_out_pin <= vbus_evt | id_evt | se1_evt | chg_evt |
                           (vbus_level_irq & ~clear_vbus_irq) |
                           (id_change_irq & ~clear_id_irq) |
                           (se1_change_irq & ~clear_se1_irq) |
                           (charger_detect_irq & ~clear_charger_irq);
    end

endmodule

// file: tb/accessory_model.sv
// Plug and accessory model: VBUS millivolts, ID condition, data lines.
// Assumes the bench sets levels after a clock edge.
`timescale 1ns/1ps
module accessory_model #(
    parameter CHG_MV = 16'h9c4
) (
    input wire [15:0] vbus_mv,
    input wire [1:0] id_mode,
    input wire se1_on,
    output wire vbus_cmp_valid,
    output wire vbus_cmp_session,
    output wire vbus_cmp_low,
    output wire id_cmp_ground,
    output wire id_cmp_open,
    output wire id_cmp_factory,
    output wire data_plus_high,
    output wire data_minus_high,
    output wire charger_detect_threshold
);
    // Three independent comparator levels and the charger threshold on VBUS
    assign vbus_cmp_valid = vbus_mv > 16'h1130;
    assign vbus_cmp_session = vbus_mv > 16'h7d0;
    assign vbus_cmp_low = vbus_mv > 16'h320;
    assign charger_detect_threshold = vbus_mv > CHG_MV;
    // ID: 0 resistor, 1 grounded, 2 floating, 3 factory
    assign id_cmp_ground = id_mode == 2'h1;
    assign id_cmp_open = id_mode[1];
    assign id_cmp_factory = id_mode == 2'h3;
    // Lines differ unless SE1, so one line alone never passes
    assign data_plus_high = se1_on | id_mode[0];
    assign data_minus_high = se1_on | ~id_mode[0];
endmodule

// file: tb/accessory_detect_monitor.sv
// Checker for the accessory detection readout ports.
// Assumes bind with the shortened valid debounce counts.
`timescale 1ns/1ps
module accessory_detect_monitor #(
    parameter VALID_RISE_CYC = 50
) (
    input wire ref_clk,
    input wire resetn,
    input wire vbus_cmp_valid,
    input wire vbus_cmp_session,
    input wire clear_id_irq,
    input wire vbus_valid_flag,
    input wire vbus_session_flag,
    input wire vbus_low_flag,
    input wire id_open_flag,
    input wire id_grounded_flag,
    input wire id_pullup_select,
    input wire se1_level_flag,
    input wire vbus_level_irq,
    input wire id_change_irq,
    input wire se1_change_irq,
    input wire charger_detect_irq,
    input wire irq_out_pin
);
    // One domain throughout
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    irq_pin_a: assert property (irq_out_pin == (vbus_level_irq | id_change_irq | se1_change_irq | charger_detect_irq))
        else $error("irq pin wrong");
    vbus_irq_a: assert property ($changed({vbus_valid_flag, vbus_session_flag, vbus_low_flag}) |-> vbus_level_irq)
        else $error("vbus irq missing");
    id_irq_a: assert property ($changed({id_open_flag, id_grounded_flag}) |-> id_change_irq)
        else $error("id irq missing");
    se1_irq_a: assert property ($changed(se1_level_flag) |-> se1_change_irq)
        else $error("se1 irq missing");
    irq_held_a: assert property (id_change_irq && !clear_id_irq |=> id_change_irq)
        else $error("id irq lost");
    no_factory_a: assert property (id_pullup_select [*4] |-> !(id_open_flag && id_grounded_flag))
        else $error("factory code seen");
    valid_rise_a: assert property ($rose(vbus_valid_flag) |-> $past(vbus_cmp_valid, VALID_RISE_CYC))
        else $error("valid rose early");
    session_a: assert property (vbus_cmp_session [*8] |=> vbus_session_flag)
        else $error("session late");
    cover property ($rose(vbus_valid_flag));
    cover property ($rose(se1_level_flag));
    cover property (id_open_flag && id_grounded_flag);
endmodule
bind accessory_detect_logic accessory_detect_monitor #(.VALID_RISE_CYC(VALID_RISE_CYC)) accessory_detect_monitor_i (.*);

// file: tb/accessory_detect_logic_test.sv
// Self-checking bench for the accessory detection readout logic.
// Assumes shortened debounce counts; the model drives all levels.
`timescale 1ns/1ps
module accessory_detect_logic_test;
    localparam CHG = 16'h9c4;
    reg ref_clk = 0, resetn = 0, wr = 0, wd = 0, s1 = 0;
    reg [3:0] clr = 0;
    reg [15:0] mv = 0, prv = 0;
    reg [1:0] idm = 0;
    reg [31:0] r;
    reg [5:0] ex = 0, last = 0;
    reg [5:0] q[$];
    wire vv, vs, vl, ig, io, ifa, dp, dm, chg;
    wire [13:0] o;
    integer fails = 0, num_checks = 0, seed = 32'hbcdd2e3f, i;
    initial forever #20 ref_clk = ~ref_clk;
    accessory_model #(.CHG_MV(CHG)) accessory_model_i (.vbus_mv(mv), .id_mode(idm), .se1_on(s1),
        .vbus_cmp_valid(vv), .vbus_cmp_session(vs), .vbus_cmp_low(vl), .id_cmp_ground(ig), .id_cmp_open(io),
        .id_cmp_factory(ifa), .data_plus_high(dp), .data_minus_high(dm), .charger_detect_threshold(chg));
    accessory_detect_logic #(.VALID_RISE_CYC(50), .VALID_FALL_CYC(10), .SESSION_FILT_CYC(4), .SE1_DEB_CYC(20))
    accessory_detect_logic_i (.ref_clk(ref_clk), .resetn(resetn), .vbus_cmp_valid(vv), .vbus_cmp_session(vs),
        .vbus_cmp_low(vl), .id_cmp_ground(ig), .id_cmp_open(io), .id_cmp_factory(ifa), .data_plus_high(dp),
        .data_minus_high(dm), .charger_detect_threshold(chg), .charger_detect_event(chg),
        .pullup_select_wr(wr), .pullup_select_wdata(wd), .clear_vbus_irq(clr[0]), .clear_id_irq(clr[1]),
        .clear_se1_irq(clr[2]), .clear_charger_irq(clr[3]), .vbus_valid_flag(o[13]), .vbus_session_flag(o[12]),
        .vbus_low_flag(o[11]), .id_open_flag(o[10]), .id_grounded_flag(o[9]), .se1_level_flag(o[8]),
        .id_pullup_select(o[7]), .se1_sense_flag(o[6]), .se1_raw_to_charger(o[5]), .vbus_level_irq(o[4]),
        .id_change_irq(o[3]), .se1_change_irq(o[2]), .charger_detect_irq(o[1]), .irq_out_pin(o[0]));
    task check(input [7:0] seen, input [7:0] want);
        begin
            num_checks = num_checks + 1;
            if (seen !== want) begin
                fails = fails + 1;
                $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
            end
        end
    endtask
    task close_out;
        begin
            $display("checks=%0d fails=%0d", num_checks, fails);
            if (fails == 0 && num_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // One level step: note expected flags, await them, check irq and clear
    task step(input [15:0] v, input [1:0] d, input e1, input sl);
        reg [5:0] e;
        integer n;
        begin
            mv = v; idm = d; s1 = e1; wd = sl; wr = 1;
            e = {v > 16'h1130, v > 16'h7d0, v > 16'h320, (d == 2'h3 && sl) ? 2'h2 : d, e1};
            if (e !== ex)
                q.push_back(e);
            @(posedge ref_clk) #2 wr = 0;
            for (n = 0; n < 200 && q.size() > 0; n = n + 1)
                @(posedge ref_clk);
            if (q.size() > 0) begin
                fails = fails + 1;
                close_out;
            end
            repeat (4) @(posedge ref_clk);
            #2 check(o[0], e !== ex || (v > CHG && prv <= CHG));
            check(o[4:1], {e[5:3] !== ex[5:3], e[2:1] !== ex[2:1], e[0] !== ex[0], v > CHG && prv <= CHG});
            check(o[5], e1);
            check(o[7], sl);
            check(o[6], e1 && v > CHG);
            clr = 4'hf;
            @(posedge ref_clk) #2 clr = 0;
            @(posedge ref_clk) #2 check(o[0], 1'h0);
            ex = e;
            prv = v;
        end
    endtask
    // Each change of the flags takes the oldest note; none left means spurious
    // Sampled mid-cycle so the flags launched at the rising edge have settled
    always @(negedge ref_clk)
        if (resetn && o[13:8] !== last) begin
            last = o[13:8];
            if (q.size() == 0)
                check(last, 8'hff);
            else
                check(last, q.pop_front());
        end
    initial begin
        repeat (10) @(posedge ref_clk);
        #2 resetn = 1;
        check(o[7:0], 8'h00);
        // Software owns the pull-up select from power-up, as it owns the power paths
        step(16'h3e8, 2'h0, 1'h0, 1'h0);
        step(16'hbb8, 2'h0, 1'h0, 1'h0);
        step(16'h1388, 2'h0, 1'h0, 1'h0);
        // Dip shorter than the fall debounce must not register
        mv = 16'hbb8;
        repeat (5) @(posedge ref_clk);
        #2 mv = 16'h1388;
        repeat (30) @(posedge ref_clk);
        #2 check(o[0], 1'h0);
        step(16'hbb8, 2'h0, 1'h0, 1'h0);
        step(16'h3e8, 2'h0, 1'h0, 1'h0);
        step(16'h0, 2'h0, 1'h0, 1'h0);
        for (i = 0; i < 8; i = i + 1) begin
            r = $random(seed);
            step(16'h0, r[1:0], 1'h0, 1'h0);
        end
        step(16'h0, 2'h3, 1'h0, 1'h0);
        step(16'h0, 2'h3, 1'h0, 1'h1);
        step(16'h0, 2'h3, 1'h0, 1'h0);
        // One flag group changes per step, except the first where low and ID change together; each step leaves a single note
        step(16'h3e8, 2'h0, 1'h0, 1'h0);
        step(16'h3e8, 2'h0, 1'h1, 1'h0);
        step(16'hbb8, 2'h0, 1'h1, 1'h0);
        step(16'hbb8, 2'h0, 1'h0, 1'h0);
        close_out;
    end
endmodule
